// ===== ursel_device.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - Tolerate one-tick high glitch between zeros
// - Sample 8th tick after start, then every 16
// - Start zero, stop one; start edge resyncs
// - Positive pulses decode at trailing edge
// - Source keeps pulse trailing edges 16 apart
// - Line BF maps first pause/resume chars
// - Line BF maps second pause/resume chars
// - Line BF maps feature register at 02
// - Host sets unlock bit keeping others
// - Unlocked, line 00, modem bit6: halt level
// - Same conditions: trigger level at 07
// - Ready status at 07 via modem rewrite
// - Restoring line value returns base map
// - Falling edge: decoded low 16 ticks
module ursel_device (
	input wire logic pclk,
	input wire logic presetn,
	ursel_if.device bus,
	input wire logic rx_invert,
	input wire logic [7:0] ready_flags,
	output logic [7:0] rx_char,
	output logic rx_char_valid,
	output logic frame_err,
	output logic [15:0] baud_divisor
);
	import ursel_pkg::*;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} ursel_rx_type;
	typedef struct packed {
		logic [7:0] div_low;
		logic [7:0] div_high;
		logic [7:0] feature;
		logic [7:0] line;
		logic [7:0] modem;
		logic [7:0] res1;
		logic [7:0] res2;
		logic [7:0] pau1;
		logic [7:0] pau2;
		logic [7:0] halt_lvl;
		logic [7:0] trig_lvl;
		logic [7:0] scratch;
		logic [7:0] rdata;
		logic rd_valid;
		logic [2:0] tsync;
		logic dprev;
		ursel_rx_type rx_st;
		logic [3:0] tcnt;
		logic [3:0] bits;
		logic [7:0] shift;
		logic [7:0] rx_char;
		logic rx_valid;
		logic ferr;
	} ursel_dev_type;
	ursel_dev_type s_r;
	ursel_dev_type s_nxt;
	ursel_sel_type sel;
	logic dec_rx;
	logic tick;
	logic unlocked;
	logic [7:0] rd_mux;
	// ==========================================
	// Infrared decoder
	ursel_decoder u_dec (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.ir_rx(bus.ir_rx),
		.invert(rx_invert),
		.dec_rx(dec_rx)
	);
	// ==========================================
	// Register selection from current contents and address
	always_comb begin
		unlocked = s_r.feature[FEATURE_UNLOCK_BIT] & s_r.modem[MODEM_EXT_BIT];
		sel = SEL_NORMAL; // Base map otherwise
		if (bus.addr == OFS_LINE) begin
			sel = SEL_LINE;
		end else if (s_r.line == LINE_DIVISOR_KEY && bus.addr == OFS_DIV_LOW) begin
			sel = SEL_DIV_LOW;
		end else if (s_r.line == LINE_DIVISOR_KEY && bus.addr == OFS_DIV_HIGH) begin
			sel = SEL_DIV_HIGH;
		end else if (s_r.line == LINE_FEATURE_KEY) begin
			unique case (bus.addr)
				OFS_FEATURE: sel = SEL_FEATURE;
				OFS_RESUME_ONE: sel = SEL_RESUME_ONE;
				OFS_PAUSE_ONE: sel = SEL_PAUSE_ONE;
				OFS_RESUME_TWO: sel = SEL_RESUME_TWO;
				OFS_PAUSE_TWO: sel = SEL_PAUSE_TWO;
				default: sel = SEL_NORMAL;
			endcase
		end else if (bus.addr == OFS_MODEM) begin
			sel = SEL_MODEM;
		end else if (unlocked && s_r.line == REG_RESET && bus.addr == OFS_PAUSE_ONE) begin
			sel = SEL_HALT_LEVEL;
		end else if (unlocked && s_r.line == REG_RESET && bus.addr == OFS_PAUSE_TWO) begin
			sel = SEL_TRIG_LEVEL;
		end else if (s_r.modem[MODEM_READY_BIT] && bus.addr == OFS_PAUSE_TWO) begin
			sel = SEL_READY;
		end else if (bus.addr == OFS_SCRATCH) begin
			sel = SEL_SCRATCH;
		end
		unique case (sel)
			SEL_DIV_LOW: rd_mux = s_r.div_low;
			SEL_DIV_HIGH: rd_mux = s_r.div_high;
			SEL_FEATURE: rd_mux = s_r.feature;
			SEL_LINE: rd_mux = s_r.line;
			SEL_MODEM: rd_mux = s_r.modem;
			SEL_RESUME_ONE: rd_mux = s_r.res1;
			SEL_RESUME_TWO: rd_mux = s_r.res2;
			SEL_PAUSE_ONE: rd_mux = s_r.pau1;
			SEL_PAUSE_TWO: rd_mux = s_r.pau2;
			SEL_HALT_LEVEL: rd_mux = s_r.halt_lvl;
			SEL_TRIG_LEVEL: rd_mux = s_r.trig_lvl;
			SEL_READY: rd_mux = ready_flags;
			SEL_SCRATCH: rd_mux = s_r.scratch;
			default: rd_mux = s_r.rx_char;
		endcase
	end
	// ==========================================
	// Register writes, reads, 16x tick and receiver
	always_comb begin
		s_nxt = s_r;
		s_nxt.rd_valid = 1'b0;
		s_nxt.rx_valid = 1'b0;
		if (bus.rd_stb) begin
			s_nxt.rdata = rd_mux;
			s_nxt.rd_valid = 1'b1;
		end
		if (bus.wr_stb) begin
			unique case (sel)
				SEL_DIV_LOW: s_nxt.div_low = bus.wdata;
				SEL_DIV_HIGH: s_nxt.div_high = bus.wdata;
				SEL_FEATURE: s_nxt.feature = bus.wdata;
				SEL_LINE: s_nxt.line = bus.wdata;
				SEL_MODEM: s_nxt.modem = bus.wdata;
				SEL_RESUME_ONE: s_nxt.res1 = bus.wdata;
				SEL_RESUME_TWO: s_nxt.res2 = bus.wdata;
				SEL_PAUSE_ONE: s_nxt.pau1 = bus.wdata;
				SEL_PAUSE_TWO: s_nxt.pau2 = bus.wdata;
				SEL_HALT_LEVEL: s_nxt.halt_lvl = bus.wdata;
				SEL_TRIG_LEVEL: s_nxt.trig_lvl = bus.wdata;
				SEL_SCRATCH: s_nxt.scratch = bus.wdata;
				default: s_nxt.scratch = s_r.scratch; // Read-only targets ignore writes
			endcase
		end
		// 16x clock pin, edge taken once stages agree
		s_nxt.tsync = {s_r.tsync[1:0], bus.oversample_clock};
		tick = s_r.tsync[1] & s_r.tsync[2] & ~s_r.dprev;
		s_nxt.dprev = (s_r.tsync[1] == s_r.tsync[2]) ? s_r.tsync[2] : s_r.dprev;
		if (tick) begin
			s_nxt.tcnt = s_r.tcnt - 4'h1;
			unique case (s_r.rx_st)
				RX_IDLE: begin
					if (!dec_rx) begin
						s_nxt.rx_st = RX_START; // Start edge resyncs strobe
						s_nxt.tcnt = MID_BIT_CYCLES_M1 - 4'h1;
					end
				end
				RX_START: begin
					if (s_r.tcnt == 4'h0) begin
						// Mid-bit check of start; glitches ignored
						s_nxt.rx_st = dec_rx ? RX_IDLE : RX_DATA;
						s_nxt.tcnt = BIT_CYCLES_M1;
						s_nxt.bits = 4'h0;
					end
				end
				RX_DATA: begin
					if (s_r.tcnt == 4'h0) begin
						s_nxt.shift = {dec_rx, s_r.shift[7:1]}; // Strobe every 16
						s_nxt.bits = s_r.bits + 4'h1;
						s_nxt.tcnt = BIT_CYCLES_M1;
						if (s_r.bits == DATA_BITS - 4'h1) begin
							s_nxt.rx_st = RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (s_r.tcnt == 4'h0) begin
						s_nxt.rx_char = s_r.shift;
						s_nxt.rx_valid = 1'b1;
						s_nxt.ferr = ~dec_rx; // Trailing one expected
						s_nxt.rx_st = RX_IDLE;
					end
				end
			endcase
		end
	end
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.line <= LINE_NORMAL;
			s_r.tsync <= 3'h0;
			s_r.rx_st <= RX_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign bus.rdata = s_r.rdata;
	assign bus.rd_valid = s_r.rd_valid;
	assign rx_char = s_r.rx_char;
	assign rx_char_valid = s_r.rx_valid;
	assign frame_err = s_r.ferr;
	assign baud_divisor = {s_r.div_high, s_r.div_low};
endmodule

// ===== ursel_pkg.sv
package ursel_pkg;
	// ==========================================
	// Register offsets on the parallel bus
	localparam logic [2:0] OFS_DIV_LOW = 3'h0;
	localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
	localparam logic [2:0] OFS_FEATURE = 3'h2;
	localparam logic [2:0] OFS_LINE = 3'h3;
	localparam logic [2:0] OFS_MODEM = 3'h4;
	localparam logic [2:0] OFS_RESUME_ONE = 3'h4;
	localparam logic [2:0] OFS_RESUME_TWO = 3'h5;
	localparam logic [2:0] OFS_PAUSE_ONE = 3'h6;
	localparam logic [2:0] OFS_PAUSE_TWO = 3'h7;
	localparam logic [2:0] OFS_SCRATCH = 3'h7;
	// ==========================================
	// Magic values and field positions
	localparam logic [7:0] LINE_DIVISOR_KEY = 8'h80;
	localparam logic [7:0] LINE_FEATURE_KEY = 8'hBF;
	localparam logic [7:0] LINE_NORMAL = 8'h03;
	localparam int FEATURE_UNLOCK_BIT = 4;
	localparam int MODEM_EXT_BIT = 6;
	localparam int MODEM_READY_BIT = 2;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ==========================================
	// Oversampling timing, in 16x clocks
	localparam logic [3:0] BIT_CYCLES_M1 = 4'hF;
	localparam logic [3:0] MID_BIT_CYCLES_M1 = 4'h7;
	localparam logic [3:0] DATA_BITS = 4'h8;
	// ==========================================
	// APB answer
	localparam logic [31:0] APB_UNMAPPED = 32'h0000_0000;
	// Host command register offsets (APB byte addresses)
	localparam logic [7:0] CMD_ADDR_OFS = 8'h00;
	localparam logic [7:0] CMD_WDATA_OFS = 8'h04;
	localparam logic [7:0] CMD_GO_OFS = 8'h08;
	localparam logic [7:0] CMD_STATUS_OFS = 8'h0C;
	localparam logic [7:0] CMD_RXCHAR_OFS = 8'h10;
	// Register selector
	typedef enum logic [3:0] {
		SEL_NORMAL = 4'h0,
		SEL_DIV_LOW = 4'h1,
		SEL_DIV_HIGH = 4'h2,
		SEL_FEATURE = 4'h3,
		SEL_LINE = 4'h4,
		SEL_MODEM = 4'h5,
		SEL_RESUME_ONE = 4'h6,
		SEL_RESUME_TWO = 4'h7,
		SEL_PAUSE_ONE = 4'h8,
		SEL_PAUSE_TWO = 4'h9,
		SEL_HALT_LEVEL = 4'hA,
		SEL_TRIG_LEVEL = 4'hB,
		SEL_READY = 4'hC,
		SEL_SCRATCH = 4'hD
	} ursel_sel_type;
endpackage

// ===== ursel_if.sv
`timescale 1ns/100ps
interface ursel_if;
	// Parallel 8-bit host bus, one access per strobe pulse
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr_stb;
	logic rd_stb;
	logic rd_valid;
	// Infrared receive pin and 16x tick
	logic ir_rx;
	logic oversample_clock;
	modport device (input addr, input wdata, output rdata, input wr_stb, input rd_stb, output rd_valid,
		input ir_rx, input oversample_clock);
	modport host (output addr, output wdata, input rdata, output wr_stb, output rd_stb, input rd_valid,
		output ir_rx, output oversample_clock);
endinterface

// ===== ursel_decoder.sv
`timescale 1ns/100ps
module ursel_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic ir_rx,
	input wire logic invert,
	output logic dec_rx
);
	import ursel_pkg::*;
	typedef struct packed {
		logic [2:0] sync;
		logic prev;
		logic [3:0] cnt;
		logic low;
		logic pend;
	} ursel_dec_type;
	ursel_dec_type s_r;
	ursel_dec_type s_nxt;
	logic lvl;
	logic fall;
	// Filtered level once second and third stages agree
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync = {s_r.sync[1:0], ir_rx ^ invert};
		lvl = (s_r.sync[1] == s_r.sync[2]) ? s_r.sync[2] : s_r.prev;
		s_nxt.prev = lvl;
		fall = s_r.prev & ~lvl; // Falling edges only: positive pulses decode at trailing edge
		if (fall) begin
			s_nxt.pend = 1'b1; // Falling edge held until next 16x tick
		end
		if (tick) begin
			if (s_r.pend | fall) begin
				s_nxt.low = 1'b1; // Decoded line low at next tick
				s_nxt.cnt = BIT_CYCLES_M1;
				s_nxt.pend = 1'b0;
			end else if (s_r.low) begin
				if (s_r.cnt == 4'h0) begin
					s_nxt.low = 1'b0; // Low for 16 ticks then high
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
		end
	end
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{sync: 3'h7, prev: 1'b1, cnt: 4'h0, low: 1'b0, pend: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign dec_rx = ~s_r.low;
endmodule

// ===== ursel_host.sv
`timescale 1ns/100ps
module ursel_host (
	input wire logic pclk,
	input wire logic presetn,
	ursel_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ir_in,
	input wire logic tick_in
);
	import ursel_pkg::*;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic busy;
		logic [7:0] rbyte;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic ir;
		logic tk;
	} ursel_host_type;
	ursel_host_type s_r;
	ursel_host_type s_nxt;
	// ==========================================
	// APB slave; GO write issues one parallel access
	always_comb begin
		s_nxt = s_r;
		s_nxt.wr = 1'b0;
		s_nxt.rd = 1'b0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.ir = ir_in;
		s_nxt.tk = tick_in;
		if (bus.rd_valid) begin
			s_nxt.rbyte = bus.rdata;
			s_nxt.busy = 1'b0;
		end
		if (psel && !penable) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = APB_UNMAPPED;
			unique case (paddr)
				CMD_ADDR_OFS: begin
					if (pwrite) s_nxt.addr = pwdata[2:0];
					s_nxt.prdata = {29'h0, s_r.addr};
				end
				CMD_WDATA_OFS: begin
					if (pwrite) s_nxt.wdata = pwdata[7:0];
					s_nxt.prdata = {24'h0, s_r.wdata};
				end
				CMD_GO_OFS: begin
					// Bit0 write, bit1 read; sequences kept by software
					if (pwrite && pwdata[0]) s_nxt.wr = 1'b1;
					if (pwrite && pwdata[1]) begin
						s_nxt.rd = 1'b1;
						s_nxt.busy = 1'b1;
					end
				end
				CMD_STATUS_OFS: s_nxt.prdata = {31'h0, s_r.busy};
				CMD_RXCHAR_OFS: s_nxt.prdata = {24'h0, s_r.rbyte};
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
	end
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.ir <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign bus.addr = s_r.addr;
	assign bus.wdata = s_r.wdata;
	assign bus.wr_stb = s_r.wr;
	assign bus.rd_stb = s_r.rd;
	assign bus.ir_rx = s_r.ir;
	assign bus.oversample_clock = s_r.tk;
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
endmodule

// ===== ursel_checker.sv
`timescale 1ns/100ps
// ====
// Host bus checker
module ursel_checker
	import ursel_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic rd_valid
);
	typedef struct packed {
		logic [7:0] line;
		logic [7:0] feat;
		logic [7:0] divh;
		logic [2:0] raddr;
	} ursel_chk_type;
	ursel_chk_type sh_r;
	ursel_chk_type sh_nxt;
	// Shadow of keyed registers
	always_comb begin
		sh_nxt = sh_r;
		if (wr_stb && addr == OFS_LINE) sh_nxt.line = wdata;
		if (wr_stb && addr == OFS_FEATURE && sh_r.line == LINE_FEATURE_KEY) sh_nxt.feat = wdata;
		if (wr_stb && addr == OFS_DIV_HIGH && sh_r.line == LINE_DIVISOR_KEY) sh_nxt.divh = wdata;
		if (rd_stb) sh_nxt.raddr = addr;
	end
	// Shadow register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_r <= {LINE_NORMAL, REG_RESET, REG_RESET, 3'h0};
		end else begin
			sh_r <= sh_nxt;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ====
	// Properties
	AST_RD_ANSWER: assert property (rd_stb |=> rd_valid)
		else $error("read answer missing");
	AST_RD_CAUSE: assert property (rd_valid |-> $past(rd_stb))
		else $error("read answer without request");
	AST_RDATA_HOLD: assert property ($changed(rdata) |-> rd_valid)
		else $error("read data moved between reads");
	AST_WR_PULSE: assert property (wr_stb |=> !wr_stb)
		else $error("write strobe too long");
	AST_STB_EXCL: assert property (!(wr_stb && rd_stb))
		else $error("read and write together");
	AST_LINE_READ: assert property (rd_valid && sh_r.raddr == OFS_LINE |-> rdata == sh_r.line)
		else $error("line control readback wrong");
	AST_DIV_READ: assert property (rd_valid && sh_r.raddr == OFS_DIV_HIGH && sh_r.line == LINE_DIVISOR_KEY
		|-> rdata == sh_r.divh)
		else $error("divisor high readback wrong");
	AST_FEAT_READ: assert property (rd_valid && sh_r.raddr == OFS_FEATURE && sh_r.line == LINE_FEATURE_KEY
		|-> rdata == sh_r.feat)
		else $error("feature readback wrong");
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import ursel_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ir_in, tick_in, rx_invert, rx_char_valid, frame_err;
	logic [7:0] paddr, ready_flags, rx_char, got_char;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] baud_divisor;
	logic [2:0] tick_cnt;
	logic err_bit;
	int errors, compares, n_char, n0;
	ursel_if bus();
	ursel_host u_ursel_host(.pclk(pclk), .presetn(presetn), .bus(bus.host), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ir_in(ir_in), .tick_in(tick_in));
	ursel_device u_ursel_device(.pclk(pclk), .presetn(presetn), .bus(bus.device), .rx_invert(rx_invert),
		.ready_flags(ready_flags), .rx_char(rx_char), .rx_char_valid(rx_char_valid), .frame_err(frame_err),
		.baud_divisor(baud_divisor));
	ursel_checker u_ursel_checker(.pclk(pclk), .presetn(presetn), .addr(bus.addr), .wdata(bus.wdata),
		.rdata(bus.rdata), .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .rd_valid(bus.rd_valid));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Oversample clock, one eighth of pclk
	always @(posedge pclk) begin
		if (!presetn) begin
			tick_cnt <= 3'h0;
			tick_in <= 1'b0;
		end else begin
			tick_cnt <= tick_cnt + 3'h1;
			tick_in <= tick_cnt[2];
		end
	end
	// Catch received characters
	always @(posedge pclk) begin
		if (!presetn) begin
			n_char <= 0;
		end else if (rx_char_valid === 1'b1) begin
			got_char <= rx_char;
			n_char <= n_char + 1;
		end
	end
	// ====
	// Tasks
	task print_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Access phase ends at the rising edge that sees pready high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			$display("BAD %0t bus answer timeout", $time);
			print_verdict();
		end
		rd = prdata;
		err_bit = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task go(input logic [2:0] ofs, input logic [7:0] v, input logic [31:0] cmd);
		int n;
		apb(1'b1, CMD_ADDR_OFS, {29'h0, ofs});
		apb(1'b1, CMD_WDATA_OFS, {24'h0, v});
		apb(1'b1, CMD_GO_OFS, cmd);
		n = 0;
		do begin
			apb(1'b0, CMD_STATUS_OFS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		if (n == 20) begin
			errors++;
			$display("BAD %0t busy timeout", $time);
			print_verdict();
		end
	endtask
	task wr(input logic [2:0] ofs, input logic [7:0] v);
		go(ofs, v, 32'h1);
	endtask
	task rdchk(input logic [2:0] ofs, input logic [7:0] exp);
		go(ofs, 8'h00, 32'h2);
		apb(1'b0, CMD_RXCHAR_OFS, 32'h0);
		chk(rd, {24'h0, exp});
	endtask
	task ir_frame(input logic [7:0] ch, input logic pos, input int jit);
		logic [9:0] bits;
		int s;
		bits = {1'b1, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			s = (i == jit) ? 8 : 7;
			for (int t = 0; t < 16; t++) begin
				@(posedge pclk);
				ir_in <= pos ^ !(!bits[i] && t >= s && t < s + 3);
				repeat (7) @(posedge pclk);
				// Decoded level at the end of the start pulse: low only for a leading fall
				if (i == 0 && t == 9) begin
					chk({31'h0, u_ursel_device.dec_rx}, {31'h0, pos ^ rx_invert});
				end
			end
		end
		repeat (400) @(posedge pclk);
	endtask
	// ====
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rx_invert, ready_flags} = '0;
		ir_in = 1'b1;
		presetn = 1'b0;
		errors = 0;
		compares = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(OFS_LINE, LINE_NORMAL);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err_bit}, 32'h1);
		chk(rd, APB_UNMAPPED);
		$display("test reset done");
		wr(OFS_LINE, LINE_DIVISOR_KEY);
		wr(OFS_DIV_LOW, 8'h34);
		wr(OFS_DIV_HIGH, 8'h12);
		rdchk(OFS_DIV_HIGH, 8'h12);
		wr(OFS_LINE, LINE_NORMAL);
		chk({16'h0, baud_divisor}, 32'h1234);
		$display("test divisor done");
		wr(OFS_LINE, LINE_FEATURE_KEY);
		for (int k = 2; k < 8; k++) if (k != 3) wr(k[2:0], 8'hA0 | k[7:0]);
		for (int k = 2; k < 8; k++) if (k != 3) rdchk(k[2:0], 8'hA0 | k[7:0]);
		wr(OFS_LINE, LINE_NORMAL);
		rdchk(OFS_SCRATCH, REG_RESET);
		$display("test characters done");
		wr(OFS_LINE, LINE_FEATURE_KEY);
		wr(OFS_FEATURE, 8'hB2);
		wr(OFS_LINE, 8'h00);
		wr(OFS_MODEM, 8'h40);
		wr(OFS_PAUSE_ONE, 8'h5A);
		wr(OFS_PAUSE_TWO, 8'hC3);
		rdchk(OFS_PAUSE_ONE, 8'h5A);
		rdchk(OFS_PAUSE_TWO, 8'hC3);
		wr(OFS_LINE, LINE_FEATURE_KEY);
		rdchk(OFS_PAUSE_ONE, 8'hA6);
		wr(OFS_FEATURE, 8'hA2);
		wr(OFS_LINE, LINE_NORMAL);
		wr(OFS_MODEM, 8'h00);
		rdchk(OFS_SCRATCH, REG_RESET);
		$display("test thresholds done");
		ready_flags <= 8'h5C;
		wr(OFS_MODEM, 8'h04);
		rdchk(OFS_SCRATCH, 8'h5C);
		wr(OFS_SCRATCH, 8'hFF);
		rdchk(OFS_SCRATCH, 8'h5C);
		wr(OFS_MODEM, 8'h00);
		$display("test ready done");
		// Delayed pulse after the start zero makes a one-tick glitch
		ir_frame(8'h5A, 1'b0, 1);
		chk(n_char, 1);
		chk({24'h0, got_char}, 32'h5A);
		chk({31'h0, frame_err}, 32'h0);
		// Positive pulses, idle low, no inversion: zero decoded at trailing edge
		@(posedge pclk);
		ir_in <= 1'b0;
		repeat (2000) @(posedge pclk);
		n0 = n_char;
		ir_frame(8'hA5, 1'b1, 99);
		chk(n_char, n0 + 1);
		chk({24'h0, got_char}, 32'hA5);
		// Inverted negative pulses take the same trailing-edge path
		@(posedge pclk);
		ir_in <= 1'b1;
		rx_invert <= 1'b1;
		repeat (200) @(posedge pclk);
		n0 = n_char;
		ir_frame(8'h3C, 1'b0, 99);
		chk(n_char, n0 + 1);
		chk({24'h0, got_char}, 32'h3C);
		chk({31'h0, frame_err}, 32'h0);
		$display("test infrared done");
		print_verdict();
	end
endmodule
